// File: rtl/host_bus_pkg.sv
/*
  Shared types and constants for the host-bus emulation master.
  Assumes a user side on mclk and a link side on its own bus clock.
*/
package host_bus_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ     = 3'b000,
    OP_WRITE    = 3'b001,
    OP_AUX_SET  = 3'b010,
    OP_AUX_READ = 3'b011,
    OP_WAIT_HI  = 3'b100,
    OP_WAIT_LO  = 3'b101
  } op_t;

  // Command word
  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_t;

  // ----------------------------------------------------------------
  // Field positions in cmd.data for OP_AUX_SET, and in answers
  // ----------------------------------------------------------------
  localparam int AUX0_VAL_BIT = 0;
  localparam int AUX1_VAL_BIT = 1;
  localparam int AUX0_DRV_BIT = 4;
  localparam int AUX1_DRV_BIT = 5;

  // ----------------------------------------------------------------
  // Bus sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_TURN   = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b100,
    ST_WAIT   = 3'b101,
    ST_DONE   = 3'b110
  } state_t;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

  // Steps a strobe or a level wait lasts before its sampled input is trusted,
  // so the three pin sampling stages never hand over a stale value
  localparam logic [1:0] SETTLE_STEPS = 2'h2;

endpackage : host_bus_pkg

// File: rtl/host_bus_master.sv
/*
  Host-bus emulation master: takes commands on mclk, runs multiplexed
  8-bit address/data bus cycles on the link clock bus_clk.
  Assumes the peripheral drives mux_addr_data_bus only while rd_n is low,
  and that the pad logic resolves the wires from the output enables.
*/
`timescale 1ns/10ps

module host_bus_master (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic host_bus_mode,
  input wire logic cmd_valid,
  input wire host_bus_pkg::cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [host_bus_pkg::DATA_W-1:0] rsp_data,
  input wire logic bus_clk,
  input wire logic [host_bus_pkg::DATA_W-1:0] mux_addr_data_bus_in,
  output logic [host_bus_pkg::DATA_W-1:0] mux_addr_data_bus_out,
  output logic mux_addr_data_bus_oe,
  output logic [host_bus_pkg::ADDR_W-1:host_bus_pkg::DATA_W] addr_hi,
  output logic select_n,
  output logic addr_latch,
  output logic read_n,
  output logic write_n,
  input wire logic cycle_ready_in,
  output logic interface_clock_out,
  input wire logic aux_pin_0_in,
  output logic aux_pin_0_out,
  output logic aux_pin_0_oe,
  input wire logic aux_pin_1_in,
  output logic aux_pin_1_out,
  output logic aux_pin_1_oe
);

  // ----------------------------------------------------------------
  // User side (mclk): command hand-off by toggle handshake
  // ----------------------------------------------------------------
  host_bus_pkg::cmd_t cmd_hold_reg;
  logic req_tgl_reg;
  logic ack_s1_reg, ack_s2_reg, ack_seen_reg;
  logic ack_tgl_reg;
  logic [host_bus_pkg::DATA_W-1:0] result_reg;

  // Ack toggle into mclk; first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end
    else
    begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // Accept one command at a time; answer when the link side reports back
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cmd_hold_reg <= '0;
      req_tgl_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= host_bus_pkg::DATA_RST;
    end
    else if (ce)
    begin
      rsp_valid <= 1'b0;
      if (cmd_valid && cmd_ready && host_bus_mode)
      begin
        cmd_hold_reg <= cmd;  // Held stable until the ack returns
        req_tgl_reg <= ~req_tgl_reg;
        cmd_ready <= 1'b0;
      end
      if (ack_s2_reg != ack_seen_reg)
      begin
        ack_seen_reg <= ack_s2_reg;
        rsp_valid <= 1'b1;
        rsp_data <= result_reg; // Stable: written before the ack toggled
        cmd_ready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link side (bus_clk): reset, enable, mode and request crossings
  // ----------------------------------------------------------------
  logic rst_s1_reg, rst_s2_reg;
  logic ce_s1_reg, ce_s2_reg;
  logic mode_s1_reg, mode_s2_reg;
  logic req_s1_reg, req_s2_reg, req_seen_reg;

  // Two-flop synchronisers for levels and the request toggle
  always_ff @(posedge bus_clk)
  begin
    rst_s1_reg <= nrst;
    rst_s2_reg <= rst_s1_reg;
    ce_s1_reg <= ce;
    ce_s2_reg <= ce_s1_reg;
    mode_s1_reg <= host_bus_mode;
    mode_s2_reg <= mode_s1_reg;
    req_s1_reg <= req_tgl_reg;
    req_s2_reg <= req_s1_reg;
  end

  wire logic lnrst = rst_s2_reg;
  wire logic lce = ce_s2_reg;

  // ----------------------------------------------------------------
  // Pin input sampling: three flops; ready and aux levels accepted when stages 2 and 3 agree, bus data taken from stage 3
  // ----------------------------------------------------------------
  logic [2:0] rdy_sh_reg, aux0_sh_reg, aux1_sh_reg;
  logic rdy_level_reg, aux0_level_reg, aux1_level_reg;
  logic [host_bus_pkg::DATA_W-1:0] din_s1_reg, din_s2_reg, din_s3_reg;

  always_ff @(posedge bus_clk)
  begin
    if (!lnrst)
    begin
      rdy_sh_reg <= 3'h7;
      aux0_sh_reg <= 3'h0;
      aux1_sh_reg <= 3'h0;
      rdy_level_reg <= 1'b1;
      aux0_level_reg <= 1'b0;
      aux1_level_reg <= 1'b0;
      din_s1_reg <= host_bus_pkg::DATA_RST;
      din_s2_reg <= host_bus_pkg::DATA_RST;
      din_s3_reg <= host_bus_pkg::DATA_RST;
    end
    else if (lce)
    begin
      rdy_sh_reg <= {rdy_sh_reg[1:0], cycle_ready_in};
      aux0_sh_reg <= {aux0_sh_reg[1:0], aux_pin_0_in};
      aux1_sh_reg <= {aux1_sh_reg[1:0], aux_pin_1_in};
      if (rdy_sh_reg[1] == rdy_sh_reg[2])
        rdy_level_reg <= rdy_sh_reg[2];
      if (aux0_sh_reg[1] == aux0_sh_reg[2])
        aux0_level_reg <= aux0_sh_reg[2];
      if (aux1_sh_reg[1] == aux1_sh_reg[2])
        aux1_level_reg <= aux1_sh_reg[2];
      din_s1_reg <= mux_addr_data_bus_in;
      din_s2_reg <= din_s1_reg;
      din_s3_reg <= din_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Interface clock: bus_clk halved, sequencer steps on its falling edge
  // ----------------------------------------------------------------
  always_ff @(posedge bus_clk)
  begin
    if (!lnrst)
      interface_clock_out <= 1'b0;
    else if (lce)
      interface_clock_out <= ~interface_clock_out;
  end

  wire logic step = interface_clock_out;

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  host_bus_pkg::state_t state_reg;
  host_bus_pkg::cmd_t cur_reg;
  logic aux1_drv_reg;
  logic [1:0] settle_reg; // Steps spent in strobe or wait so far

  // Access cycle, aux pins and answer word; one process keeps pins coherent
  always_ff @(posedge bus_clk)
  begin
    if (!lnrst)
    begin
      state_reg <= host_bus_pkg::ST_IDLE;
      cur_reg <= '0;
      req_seen_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      result_reg <= host_bus_pkg::DATA_RST;
      mux_addr_data_bus_out <= host_bus_pkg::DATA_RST;
      mux_addr_data_bus_oe <= 1'b0;
      addr_hi <= host_bus_pkg::ADDR_RST[host_bus_pkg::ADDR_W-1:host_bus_pkg::DATA_W];
      select_n <= 1'b1;
      addr_latch <= 1'b0;
      read_n <= 1'b1;
      write_n <= 1'b1;
      aux_pin_0_out <= 1'b0;
      aux_pin_0_oe <= 1'b0;
      aux_pin_1_out <= 1'b0;
      aux_pin_1_oe <= 1'b0;
      aux1_drv_reg <= 1'b0;
      settle_reg <= 2'h0;
    end
    else if (lce && step)
    begin
      case (state_reg)
        host_bus_pkg::ST_IDLE:
        begin
          if (req_s2_reg != req_seen_reg && mode_s2_reg)
          begin
            req_seen_reg <= req_s2_reg;
            cur_reg <= cmd_hold_reg; // Stable while the request is pending
            case (cmd_hold_reg.op)
              host_bus_pkg::OP_READ, host_bus_pkg::OP_WRITE:
              begin
                mux_addr_data_bus_out <= cmd_hold_reg.addr[host_bus_pkg::DATA_W-1:0];
                mux_addr_data_bus_oe <= 1'b1;
                addr_hi <= cmd_hold_reg.addr[host_bus_pkg::ADDR_W-1:host_bus_pkg::DATA_W];
                select_n <= 1'b0;
                addr_latch <= 1'b1;
                state_reg <= host_bus_pkg::ST_ADDR;
              end
              host_bus_pkg::OP_AUX_SET:
              begin
                aux_pin_0_out <= cmd_hold_reg.data[host_bus_pkg::AUX0_VAL_BIT];
                aux_pin_0_oe <= cmd_hold_reg.data[host_bus_pkg::AUX0_DRV_BIT];
                aux_pin_1_out <= cmd_hold_reg.data[host_bus_pkg::AUX1_VAL_BIT];
                aux_pin_1_oe <= cmd_hold_reg.data[host_bus_pkg::AUX1_DRV_BIT];
                aux1_drv_reg <= cmd_hold_reg.data[host_bus_pkg::AUX1_DRV_BIT];
                result_reg <= host_bus_pkg::DATA_RST;
                state_reg <= host_bus_pkg::ST_DONE;
              end
              host_bus_pkg::OP_AUX_READ:
              begin
                result_reg <= host_bus_pkg::DATA_RST;
                result_reg[host_bus_pkg::AUX0_VAL_BIT] <= aux0_level_reg;
                result_reg[host_bus_pkg::AUX1_VAL_BIT] <= aux1_level_reg;
                state_reg <= host_bus_pkg::ST_DONE;
              end
              host_bus_pkg::OP_WAIT_HI, host_bus_pkg::OP_WAIT_LO:
              begin
                aux_pin_1_oe <= 1'b0;
                settle_reg <= 2'h0;
                state_reg <= host_bus_pkg::ST_WAIT;
              end
              default:
              begin
                result_reg <= host_bus_pkg::DATA_RST; // Unknown opcode answers zero
                state_reg <= host_bus_pkg::ST_DONE;
              end
            endcase
          end
        end
        host_bus_pkg::ST_ADDR:
        begin
          addr_latch <= 1'b0;
          if (cur_reg.op == host_bus_pkg::OP_WRITE)
            mux_addr_data_bus_out <= cur_reg.data;
          else
            mux_addr_data_bus_oe <= 1'b0;
          state_reg <= host_bus_pkg::ST_TURN;
        end
        host_bus_pkg::ST_TURN:
        begin
          // Strobe falls one step after data or release settled
          if (cur_reg.op == host_bus_pkg::OP_WRITE)
            write_n <= 1'b0;
          else
            read_n <= 1'b0;
          settle_reg <= 2'h0;
          state_reg <= host_bus_pkg::ST_STROBE;
        end
        host_bus_pkg::ST_STROBE:
        begin
          // Data and ready lag the pins by the sampling stages; a minimum strobe covers that lag
          if (settle_reg != host_bus_pkg::SETTLE_STEPS)
            settle_reg <= settle_reg + 2'h1;
          else if (rdy_level_reg)
          begin
            read_n <= 1'b1;
            write_n <= 1'b1;
            if (cur_reg.op == host_bus_pkg::OP_READ)
              result_reg <= din_s3_reg;
            else
              result_reg <= host_bus_pkg::DATA_RST;
            state_reg <= host_bus_pkg::ST_HOLD;
          end
        end
        host_bus_pkg::ST_HOLD:
        begin
          mux_addr_data_bus_oe <= 1'b0;
          select_n <= 1'b1;
          state_reg <= host_bus_pkg::ST_DONE;
        end
        host_bus_pkg::ST_WAIT:
        begin
          // Halts all sequencing until the level is seen; the sampler first forgets the driven level
          if (settle_reg != host_bus_pkg::SETTLE_STEPS)
            settle_reg <= settle_reg + 2'h1;
          else if (aux1_level_reg == (cur_reg.op == host_bus_pkg::OP_WAIT_HI))
          begin
            aux_pin_1_oe <= aux1_drv_reg;
            result_reg <= host_bus_pkg::DATA_RST;
            state_reg <= host_bus_pkg::ST_DONE;
          end
        end
        host_bus_pkg::ST_DONE:
        begin
          ack_tgl_reg <= ~ack_tgl_reg; // result_reg settled at least a step earlier
          state_reg <= host_bus_pkg::ST_IDLE;
        end
        default:
          state_reg <= host_bus_pkg::ST_IDLE;
      endcase
    end
  end

endmodule : host_bus_master

// File: tb/host_bus_checker.sv
/* Port assertions for host_bus_master.
   Assumes binding into every host_bus_master instance. */
`timescale 1ns/10ps
module host_bus_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic host_bus_mode,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic bus_clk,
  input wire logic [7:0] mux_addr_data_bus_out,
  input wire logic mux_addr_data_bus_oe,
  input wire logic [15:8] addr_hi,
  input wire logic select_n,
  input wire logic addr_latch,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic cycle_ready_in,
  input wire logic interface_clock_out
);
  // Strobe held while the peripheral keeps ready low
  sequence s_stall;
    (!(read_n && write_n) && !cycle_ready_in) [*6];
  endsequence
  sequence s_edge_wr;
    $rose(write_n) || $fell(write_n);
  endsequence
  // User side handshake
  a_take_drop: assert property (@(posedge mclk) disable iff (!nrst)
    cmd_valid && cmd_ready && host_bus_mode && ce |=> !cmd_ready) else $error("ready kept after accept");
  a_rsp_ready: assert property (@(posedge mclk) disable iff (!nrst)
    rsp_valid |-> cmd_ready && $past(!cmd_ready)) else $error("answer without ready rise");
  // Link side pin relations
  a_latch_width: assert property (@(posedge bus_clk) disable iff (!nrst)
    $rose(addr_latch) |=> addr_latch ##1 !addr_latch) else $error("latch pulse width wrong");
  a_latch_addr: assert property (@(posedge bus_clk) disable iff (!nrst)
    addr_latch |-> mux_addr_data_bus_oe && !select_n && read_n && write_n) else $error("latch phase wrong");
  a_read_bus: assert property (@(posedge bus_clk) disable iff (!nrst)
    !read_n |-> !mux_addr_data_bus_oe && !select_n && write_n) else $error("read phase wrong");
  a_write_hold: assert property (@(posedge bus_clk) disable iff (!nrst)
    s_edge_wr |-> mux_addr_data_bus_oe && !select_n && $stable(mux_addr_data_bus_out)) else $error("write data moved");
  a_ready_stall: assert property (@(posedge bus_clk) disable iff (!nrst)
    s_stall |=> !(read_n && write_n)) else $error("strobe ended while not ready");
  a_addr_stable: assert property (@(posedge bus_clk) disable iff (!nrst)
    !select_n && !$fell(select_n) |-> $stable(addr_hi)) else $error("upper address moved");
  a_clk_out: assert property (@(posedge bus_clk) disable iff (!nrst)
    interface_clock_out && $past(ce) |=> !interface_clock_out) else $error("clock out stuck high");
  a_pin_step: assert property (@(posedge bus_clk) disable iff (!nrst)
    $changed(select_n) || $changed(addr_latch) |-> $fell(interface_clock_out)) else $error("pin off clock step");
endmodule : host_bus_checker

bind host_bus_master host_bus_checker i_chk (.mclk(mclk), .nrst(nrst), .ce(ce), .host_bus_mode(host_bus_mode),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .bus_clk(bus_clk),
  .mux_addr_data_bus_out(mux_addr_data_bus_out), .mux_addr_data_bus_oe(mux_addr_data_bus_oe),
  .addr_hi(addr_hi), .select_n(select_n), .addr_latch(addr_latch), .read_n(read_n), .write_n(write_n),
  .cycle_ready_in(cycle_ready_in), .interface_clock_out(interface_clock_out));

// File: tb/periph_model.sv
/* Behavioural peripheral on the multiplexed bus, with memory and ready.
   Assumes the master's pins drive it directly. */
`timescale 1ns/10ps
module periph_model (
  input wire logic bus_clk,
  input wire logic [7:0] ad_out,
  input wire logic [15:8] addr_hi,
  input wire logic select_n,
  input wire logic addr_latch,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [7:0] stall,
  output logic [7:0] ad_in,
  output logic ready
);
  logic [7:0] mem [logic [15:0]];
  logic [15:0] addr;
  initial ready = 1'b1;
  initial ad_in = 8'hA5;
  // Address taken on clock edges while the latch is high; no race with the data swap
  always @(posedge bus_clk)
    if (addr_latch)
      addr <= {addr_hi, ad_out};
  // Write stored as the strobe rises
  always @(posedge write_n)
    if (!select_n)
      mem[addr] = ad_out;
  // Released bus toggles so stale data never passes
  always @(posedge bus_clk)
    ad_in <= !read_n ? (mem.exists(addr) ? mem[addr] : 8'h00) : ~ad_in;
  // Decode delay: ready pulled low early enough to stretch
  always @(posedge addr_latch)
    if (stall != 8'h00)
    begin
      ready <= 1'b0;
      repeat (stall) @(posedge bus_clk);
      ready <= 1'b1;
    end
endmodule : periph_model

// File: tb/mcu_host_bus_emulation_tb.sv
/* Self-checking bench: master, peripheral model, aux pin drivers.
   Assumes the package, master and checker are compiled first. */
`timescale 1ns/10ps
module mcu_host_bus_emulation_tb;
  logic mclk = 1'b0;
  logic bus_clk = 1'b0;
  logic nrst = 1'b0;
  logic mode = 1'b1;
  logic ce = 1'b1;
  logic cmd_valid = 1'b0;
  host_bus_pkg::cmd_t cmd = '0;
  logic cmd_ready, rsp_valid, m_oe, sel_n, ale, rd_n, wr_n, rdy, clk_out;
  logic [7:0] rsp_data, m_out, p_ad;
  logic [7:0] stall = 8'h00;
  logic [15:8] a_hi;
  logic a0_o, a0_e, a1_o, a1_e;
  logic ext0 = 1'b0;
  logic ext1 = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'h5F6E;
  logic [15:0] adr [6];
  logic [7:0] dat [6];
  always #5 mclk = ~mclk;
  always #6 bus_clk = ~bus_clk;
  host_bus_master i_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .host_bus_mode(mode), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus_clk(bus_clk),
    .mux_addr_data_bus_in(m_oe ? m_out : p_ad), .mux_addr_data_bus_out(m_out), .mux_addr_data_bus_oe(m_oe),
    .addr_hi(a_hi), .select_n(sel_n), .addr_latch(ale), .read_n(rd_n), .write_n(wr_n), .cycle_ready_in(rdy),
    .interface_clock_out(clk_out), .aux_pin_0_in(a0_e ? a0_o : ext0), .aux_pin_0_out(a0_o),
    .aux_pin_0_oe(a0_e), .aux_pin_1_in(a1_e ? a1_o : ext1), .aux_pin_1_out(a1_o), .aux_pin_1_oe(a1_e));
  periph_model i_per (.bus_clk(bus_clk), .ad_out(m_out), .addr_hi(a_hi), .select_n(sel_n), .addr_latch(ale),
    .read_n(rd_n), .write_n(wr_n), .stall(stall), .ad_in(p_ad), .ready(rdy));
  // Expected answer of an aux sample
  function automatic logic [7:0] aux_word(input logic a0, input logic a1);
    return {6'h00, a1, a0};
  endfunction : aux_word
  // Expected read: the last write that went to the same address
  function automatic logic [7:0] rd_exp(input int idx);
    logic [7:0] v;
    v = dat[idx];
    for (int j = 0; j < 6; j++)
      if (adr[j] == adr[idx])
        v = dat[j];
    return v;
  endfunction : rd_exp
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Offer at a falling edge; accepted once ready is seen low
  task automatic issue(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
    cmd = {op, a, d};
    cmd_valid = 1'b1;
    for (int i = 0; i < 50 && cmd_ready; i++)
      @(negedge mclk);
    cmd_valid = 1'b0;
    if (cmd_ready !== 1'b0)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask : issue
  // Bounded wait for the one-cycle answer pulse
  task automatic fin(input logic [7:0] exp, input logic cmp);
    for (int i = 0; i < 3000 && rsp_valid !== 1'b1; i++)
      @(negedge mclk);
    if (rsp_valid !== 1'b1)
    begin
      n_mismatch++;
      wrap_up();
    end
    if (cmp)
      chk(rsp_data, exp);
  endtask : fin
  task automatic run(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
    issue(op, a, d);
    fin(e, 1'b1);
  endtask : run
  initial
  begin
    logic seen;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    repeat (10) @(negedge mclk);
    // Offers refused while the clock enable is low, then while the mode is off
    ce = 1'b0;
    cmd_valid = 1'b1;
    repeat (8) @(negedge mclk);
    chk({7'h00, cmd_ready}, 8'h01);
    ce = 1'b1;
    mode = 1'b0;
    repeat (8) @(negedge mclk);
    chk({7'h00, cmd_ready}, 8'h01);
    cmd_valid = 1'b0;
    mode = 1'b1;
    // Writes at corner and random addresses, then reads back reversed
    for (int i = 0; i < 6; i++)
    begin
      adr[i] = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
      dat[i] = 8'($random(seed));
      stall = (i == 3) ? 8'h28 : 8'($random(seed)) & 8'h0F;
      run(host_bus_pkg::OP_WRITE, adr[i], dat[i], 8'h00);
    end
    for (int i = 5; i >= 0; i--)
    begin
      stall = (i == 2) ? 8'h28 : 8'($random(seed)) & 8'h0F;
      run(host_bus_pkg::OP_READ, adr[i], 8'h00, rd_exp(i));
    end
    // Aux pins driven high, driven low, then sampled as inputs
    for (int k = 0; k < 3; k++)
    begin
      ext0 = (k == 2);
      run(host_bus_pkg::OP_AUX_SET, 16'h0000, (k == 0) ? 8'h33 : (k == 1) ? 8'h30 : 8'h00, 8'h00);
      run(host_bus_pkg::OP_AUX_READ, 16'h0000, 8'h00, aux_word(k != 1, k == 0));
    end
    // Wait on aux 1 level with the pin previously driven
    for (int k = 0; k < 2; k++)
    begin
      run(host_bus_pkg::OP_AUX_SET, 16'h0000, {7'h10, k[0]}, 8'h00);
      issue(k[0] ? host_bus_pkg::OP_WAIT_LO : host_bus_pkg::OP_WAIT_HI, 16'h0000, 8'h00);
      seen = 1'b0;
      repeat (100) @(negedge mclk) seen |= rsp_valid;
      chk({7'h00, seen}, 8'h00);
      chk({7'h00, a1_e}, 8'h00);
      ext1 = ~ext1;
      fin(8'h00, 1'b0);
    end
    run(3'h7, 16'h1234, 8'h55, 8'h00);
    wrap_up();
  end
endmodule : mcu_host_bus_emulation_tb
